// [design/ebpc_pin_ctrl.sv]
// Pin state control of the external expansion bus in each operating condition.
`timescale 1ns/1ps
`include "ebpc_params.svh"
// Function
// [RQ1] After reset all bus pins except clock output float until expansion is selected.
// [RQ2] Address/data lines float except during active external bus cycles.
// [RQ3] Low address floats in reset; holds last cycle value in other states.
// [RQ4] High address holds in halt/inactive; floats in reset, stop, hold.
// [RQ5] Byte enables hold in halt/inactive; float in reset, stop, hold.
// [RQ6] Read/write status high in halt/inactive; floats in reset, stop, hold.
// [RQ7] Strobes high in halt/inactive; float in reset, stop, hold.
// [RQ8] Address strobe high in halt/inactive; floats in reset, stop, hold.
// [RQ9] Hold acknowledge low in hold, normal in halt/inactive, floats otherwise; the code also drives it high in active cycles.
// [RQ10] Hold request monitored in halt, hold, inactive; ignored in reset, stop.
// [RQ11] Clock output floats in reset, low in stop, runs otherwise unless inhibited.
// [RQ12] Internal fetch in expansion mode puts the bus into the inactive state.
// [RQ13] Held values are undefined before the first external access.
// [RQ14] Held outputs show the most recent external bus cycle, across mode toggles.
// [RQ15] Held values are registers updated only during active external cycles.
module ebpc_pin_ctrl (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   expansion_mode_in,
  input  wire logic                   ext_cycle_in,
  input  wire logic                   internal_fetch_in,
  input  wire logic                   halt_in,
  input  wire logic                   stop_in,
  input  wire logic                   system_clock_output_inhibit_in,
  input  wire logic                   cycle_ad_drive_in,
  input  wire logic [`EBPC_AD_W-1:0]  cycle_ad_in,
  input  wire logic [`EBPC_LA_W-1:0]  cycle_low_addr_in,
  input  wire logic [`EBPC_HA_W-1:0]  cycle_high_addr_in,
  input  wire logic                   cycle_low_be_n_in,
  input  wire logic                   cycle_high_be_n_in,
  input  wire logic                   cycle_read_in,
  input  wire logic                   cycle_data_strobe_n_in,
  input  wire logic                   cycle_read_strobe_n_in,
  input  wire logic                   cycle_write_low_n_in,
  input  wire logic                   cycle_write_high_n_in,
  input  wire logic                   cycle_addr_strobe_n_in,
  input  wire logic                   hold_request_n_in,
  input  wire logic                   clk_phase_in,
  output logic [`EBPC_AD_W-1:0]       mux_addr_data_lines_out,
  output logic                        mux_addr_data_lines_oe_out,
  output logic [`EBPC_LA_W-1:0]       low_address_lines_out,
  output logic                        low_address_lines_oe_out,
  output logic [`EBPC_HA_W-1:0]       high_address_lines_out,
  output logic                        high_address_lines_oe_out,
  output logic                        low_byte_enable_n_out,
  output logic                        high_byte_enable_n_out,
  output logic                        byte_enable_oe_out,
  output logic                        read_write_status_out,
  output logic                        read_write_status_oe_out,
  output logic                        data_strobe_n_out,
  output logic                        read_strobe_n_out,
  output logic                        write_strobe_low_n_out,
  output logic                        write_strobe_high_n_out,
  output logic                        strobe_oe_out,
  output logic                        address_strobe_n_out,
  output logic                        address_strobe_oe_out,
  output logic                        hold_acknowledge_n_out,
  output logic                        hold_acknowledge_oe_out,
  output logic                        hold_request_seen_out,
  output logic                        system_clock_output_out,
  output logic                        system_clock_output_oe_out
);

  ebpc_pkg::ebpc_state_t state;
  ebpc_pkg::ebpc_state_t next_state;
  // Held copies of the last external cycle.
  logic [`EBPC_LA_W-1:0] held_low_addr;
  logic [`EBPC_LA_W-1:0] next_held_low_addr;
  logic [`EBPC_HA_W-1:0] held_high_addr;
  logic [`EBPC_HA_W-1:0] next_held_high_addr;
  logic                  held_low_be_n;
  logic                  next_held_low_be_n;
  logic                  held_high_be_n;
  logic                  next_held_high_be_n;
  logic                  hold_req_q;
  logic                  next_hold_req_q;

  // Next values of the registered pins and their enables.
  logic [`EBPC_AD_W-1:0] next_ad;
  logic                  next_ad_oe;
  logic [`EBPC_LA_W-1:0] next_la;
  logic                  next_la_oe;
  logic [`EBPC_HA_W-1:0] next_ha;
  logic                  next_ha_oe;
  logic                  next_lbe;
  logic                  next_hbe;
  logic                  next_be_oe;
  logic                  next_rw;
  logic                  next_rw_oe;
  logic                  next_ds;
  logic                  next_rd;
  logic                  next_wl;
  logic                  next_wh;
  logic                  next_st_oe;
  logic                  next_as;
  logic                  next_as_oe;
  logic                  next_ak;
  logic                  next_ak_oe;
  logic                  next_clk;
  logic                  next_clk_oe;

  // Operating state selection; stop outranks hold, hold outranks halt.
  always_comb begin
    if (!expansion_mode_in) begin
      next_state = ebpc_pkg::EBPC_RESET; // [RQ1]
    end else if (stop_in) begin
      next_state = ebpc_pkg::EBPC_STOP;
    end else if (!hold_request_n_in) begin
      next_state = ebpc_pkg::EBPC_HOLD;
    end else if (halt_in) begin
      next_state = ebpc_pkg::EBPC_HALT;
    end else if (ext_cycle_in && !internal_fetch_in) begin
      next_state = ebpc_pkg::EBPC_ACTIVE;
    end else begin
      next_state = ebpc_pkg::EBPC_INACTIVE; // [RQ12]
    end
  end

  // Held values follow the bus only in active cycles and survive mode toggles.
  always_comb begin
    next_held_low_addr  = held_low_addr;
    next_held_high_addr = held_high_addr;
    next_held_low_be_n  = held_low_be_n;
    next_held_high_be_n = held_high_be_n;
    if (next_state == ebpc_pkg::EBPC_ACTIVE) begin // [RQ15] [RQ14]
      next_held_low_addr  = cycle_low_addr_in;
      next_held_high_addr = cycle_high_addr_in;
      next_held_low_be_n  = cycle_low_be_n_in;
      next_held_high_be_n = cycle_high_be_n_in;
    end
  end

  // Hold request is sampled only where it is monitored.
  always_comb begin
    next_hold_req_q = hold_req_q;
    unique case (next_state)
      ebpc_pkg::EBPC_RESET,
      ebpc_pkg::EBPC_STOP: next_hold_req_q = 1'b0; // [RQ10]
      default: next_hold_req_q = !hold_request_n_in; // [RQ10]
    endcase
  end

  // Pin values and enables per operating state.
  always_comb begin
    next_ad     = `EBPC_AD_RST;
    next_ad_oe  = 1'b0;
    next_la     = next_held_low_addr;
    next_la_oe  = 1'b1;
    next_ha     = next_held_high_addr;
    next_ha_oe  = 1'b0;
    next_lbe    = next_held_low_be_n;
    next_hbe    = next_held_high_be_n;
    next_be_oe  = 1'b0;
    next_rw     = 1'b1;
    next_rw_oe  = 1'b0;
    next_ds     = 1'b1;
    next_rd     = 1'b1;
    next_wl     = 1'b1;
    next_wh     = 1'b1;
    next_st_oe  = 1'b0;
    next_as     = 1'b1;
    next_as_oe  = 1'b0;
    next_ak     = 1'b1;
    next_ak_oe  = 1'b0;
    next_clk    = clk_phase_in && !system_clock_output_inhibit_in; // [RQ11]
    next_clk_oe = 1'b1;
    unique case (next_state)
      ebpc_pkg::EBPC_RESET: begin
        // Port mode floats the bus pins; the clock output keeps running, but is parked low while stop_in is set.
        next_la_oe = 1'b0; // [RQ1] [RQ3]
        if (stop_in) begin
          next_clk = 1'b0; // [RQ11]
        end
      end
      ebpc_pkg::EBPC_STOP: begin
        // Stop floats the bus control pins and parks the clock output low.
        next_clk = 1'b0; // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ11]
      end
      ebpc_pkg::EBPC_HOLD: begin
        // The bus is lent out; besides the held low address and the clock output, only the acknowledge is driven, and it is driven low.
        next_ak    = 1'b0; // [RQ9]
        next_ak_oe = 1'b1;
      end
      ebpc_pkg::EBPC_ACTIVE: begin
        // Address, data, byte enable, status and strobe pins follow the running external cycle; the acknowledge is driven high.
        next_ad    = cycle_ad_in;
        next_ad_oe = cycle_ad_drive_in; // [RQ2]
        next_ha_oe = 1'b1;
        next_be_oe = 1'b1;
        next_rw    = cycle_read_in;
        next_rw_oe = 1'b1;
        next_ds    = cycle_data_strobe_n_in;
        next_rd    = cycle_read_strobe_n_in;
        next_wl    = cycle_write_low_n_in;
        next_wh    = cycle_write_high_n_in;
        next_st_oe = 1'b1;
        next_as    = cycle_addr_strobe_n_in;
        next_as_oe = 1'b1;
        next_ak_oe = 1'b1;
      end
      default: begin
        // Halt and inactive states drive the strobes high and show held values.
        next_ha_oe = 1'b1; // [RQ4] [RQ13]
        next_be_oe = 1'b1; // [RQ5]
        next_rw_oe = 1'b1; // [RQ6]
        next_st_oe = 1'b1; // [RQ7]
        next_as_oe = 1'b1; // [RQ8]
        next_ak_oe = 1'b1; // [RQ9]
      end
    endcase
  end

  // Registers the operating state.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= ebpc_pkg::EBPC_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Registers the held copies of the last external cycle.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      // Values before the first external cycle are undefined; these are arbitrary.
      held_low_addr  <= `EBPC_LA_RST; // [RQ13]
      held_high_addr <= `EBPC_HA_RST;
      held_low_be_n  <= 1'b1;
      held_high_be_n <= 1'b1;
    end else begin
      held_low_addr  <= next_held_low_addr;
      held_high_addr <= next_held_high_addr;
      held_low_be_n  <= next_held_low_be_n;
      held_high_be_n <= next_held_high_be_n;
    end
  end

  // Registers the hold request sample and its status output.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hold_req_q            <= 1'b0;
      hold_request_seen_out <= 1'b0;
    end else begin
      hold_req_q            <= next_hold_req_q;
      hold_request_seen_out <= next_hold_req_q; // [RQ10]
    end
  end

  // Registers the pin values and enables.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mux_addr_data_lines_out    <= `EBPC_AD_RST;
      mux_addr_data_lines_oe_out <= 1'b0;
      low_address_lines_out      <= `EBPC_LA_RST;
      low_address_lines_oe_out   <= 1'b0;
      high_address_lines_out     <= `EBPC_HA_RST;
      high_address_lines_oe_out  <= 1'b0;
      low_byte_enable_n_out      <= 1'b1;
      high_byte_enable_n_out     <= 1'b1;
      byte_enable_oe_out         <= 1'b0;
      read_write_status_out      <= 1'b1;
      read_write_status_oe_out   <= 1'b0;
      data_strobe_n_out          <= 1'b1;
      read_strobe_n_out          <= 1'b1;
      write_strobe_low_n_out     <= 1'b1;
      write_strobe_high_n_out    <= 1'b1;
      strobe_oe_out              <= 1'b0;
      address_strobe_n_out       <= 1'b1;
      address_strobe_oe_out      <= 1'b0;
      hold_acknowledge_n_out     <= 1'b1;
      hold_acknowledge_oe_out    <= 1'b0;
      system_clock_output_out    <= 1'b0;
      system_clock_output_oe_out <= 1'b0;
    end else begin
      mux_addr_data_lines_out    <= next_ad;
      mux_addr_data_lines_oe_out <= next_ad_oe;
      low_address_lines_out      <= next_la;
      low_address_lines_oe_out   <= next_la_oe;
      high_address_lines_out     <= next_ha;
      high_address_lines_oe_out  <= next_ha_oe;
      low_byte_enable_n_out      <= next_lbe;
      high_byte_enable_n_out     <= next_hbe;
      byte_enable_oe_out         <= next_be_oe;
      read_write_status_out      <= next_rw;
      read_write_status_oe_out   <= next_rw_oe;
      data_strobe_n_out          <= next_ds;
      read_strobe_n_out          <= next_rd;
      write_strobe_low_n_out     <= next_wl;
      write_strobe_high_n_out    <= next_wh;
      strobe_oe_out              <= next_st_oe;
      address_strobe_n_out       <= next_as;
      address_strobe_oe_out      <= next_as_oe;
      hold_acknowledge_n_out     <= next_ak;
      hold_acknowledge_oe_out    <= next_ak_oe;
      system_clock_output_out    <= next_clk;
      system_clock_output_oe_out <= next_clk_oe;
    end
  end

endmodule : ebpc_pin_ctrl

// [design/ebpc_params.svh]
// Timing-free constants and reset values for the expansion bus pin state control.
`ifndef EBPC_PARAMS_SVH
`define EBPC_PARAMS_SVH
`define EBPC_AD_W 16
`define EBPC_LA_W 15
`define EBPC_HA_W 6
`define EBPC_LA_RST 15'h0000
`define EBPC_HA_RST 6'h00
`define EBPC_AD_RST 16'h0000
`endif

// [design/ebpc_pkg.sv]
// Types for the expansion bus pin state control.
package ebpc_pkg;
  typedef enum logic [2:0] {
    EBPC_RESET,
    EBPC_ACTIVE,
    EBPC_INACTIVE,
    EBPC_HALT,
    EBPC_STOP,
    EBPC_HOLD
  } ebpc_state_t;
endpackage : ebpc_pkg

// [dv/ebpc_hold_mst.sv]
// Bus hold master model that asks for the bus and watches the grant.
`timescale 1ns/1ps
module ebpc_hold_mst (
  input  wire logic mclk_in,
  input  wire logic want_in,
  input  wire logic ack_n_in,
  input  wire logic ack_oe_in,
  output logic      hold_request_n_out,
  output logic      granted_out
);
  initial hold_request_n_out = 1'b1;
  // The request changes only just after an edge and stands while the master wants the bus.
  always @(posedge mclk_in) hold_request_n_out <= #1 !want_in;
  // An undriven acknowledge line counts as no grant.
  assign granted_out = ack_oe_in && !ack_n_in;
endmodule : ebpc_hold_mst

// [dv/ebpc_pin_ctrl_chk.sv]
// Checker of the bus pin states, bound to the pin state control.
`timescale 1ns/1ps
`include "ebpc_params.svh"
module ebpc_pin_ctrl_chk (
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic                  expansion_mode_in,
  input wire logic                  ext_cycle_in,
  input wire logic                  internal_fetch_in,
  input wire logic                  halt_in,
  input wire logic                  stop_in,
  input wire logic                  hold_request_n_in,
  input wire logic [`EBPC_LA_W-1:0] cycle_low_addr_in,
  input wire logic [`EBPC_LA_W-1:0] low_address_lines_out,
  input wire logic                  low_address_lines_oe_out,
  input wire logic                  mux_addr_data_lines_oe_out,
  input wire logic                  high_address_lines_oe_out,
  input wire logic                  byte_enable_oe_out,
  input wire logic                  read_write_status_out,
  input wire logic                  read_write_status_oe_out,
  input wire logic                  data_strobe_n_out,
  input wire logic                  strobe_oe_out,
  input wire logic                  hold_acknowledge_n_out,
  input wire logic                  hold_acknowledge_oe_out,
  input wire logic                  hold_request_seen_out,
  input wire logic                  system_clock_output_out,
  input wire logic                  system_clock_output_oe_out
);
  wire logic ok  = rst_n_in & expansion_mode_in;
  wire logic act = ok & ext_cycle_in & !internal_fetch_in & !halt_in & !stop_in &
                   hold_request_n_in;
  wire logic qt  = ok & !stop_in & hold_request_n_in & !act;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_port_float: assert property ($past(rst_n_in) && !$past(expansion_mode_in) |->
    !(mux_addr_data_lines_oe_out | low_address_lines_oe_out | high_address_lines_oe_out |
      byte_enable_oe_out | read_write_status_oe_out | strobe_oe_out | hold_acknowledge_oe_out)
    && system_clock_output_oe_out) else $error("bus pin driven in port mode");
  a_ad_drive: assert property (mux_addr_data_lines_oe_out |-> $past(act))
    else $error("address/data driven outside a cycle");
  a_low_held: assert property ($past(ok) && $past(ok, 2) && !$past(act) |->
    $stable(low_address_lines_out)) else $error("held low address changed");
  a_low_cycle: assert property ($past(act) |-> low_address_lines_oe_out &&
    low_address_lines_out == $past(cycle_low_addr_in)) else $error("low address not cycle value");
  a_hold_float: assert property (
    $past(ok && (stop_in || !hold_request_n_in)) |->
    !(high_address_lines_oe_out | byte_enable_oe_out | read_write_status_oe_out | strobe_oe_out))
    else $error("pin driven in hold or stop");
  a_quiet_high: assert property ($past(qt) |-> read_write_status_oe_out &&
    read_write_status_out && strobe_oe_out && data_strobe_n_out && high_address_lines_oe_out &&
    byte_enable_oe_out) else $error("idle pins not driven high or held");
  a_hold_ack: assert property ($past(ok && !stop_in && !hold_request_n_in) |->
    hold_acknowledge_oe_out && !hold_acknowledge_n_out && hold_request_seen_out)
    else $error("hold not acknowledged");
  a_req_ignore: assert property ($past(!ok || stop_in) |->
    !hold_request_seen_out && !hold_acknowledge_oe_out) else $error("hold request not ignored");
  a_clock_stop: assert property ($past(ok && stop_in) |->
    system_clock_output_oe_out && !system_clock_output_out) else $error("clock not low in stop");
endmodule : ebpc_pin_ctrl_chk

// [dv/tb_ebpc_pin_ctrl.sv]
// Testbench of the expansion bus pin state control.
`timescale 1ns/1ps
`include "ebpc_params.svh"
module tb_ebpc_pin_ctrl;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, expansion_mode_in, ext_cycle_in, internal_fetch_in;
  logic halt_in, stop_in, system_clock_output_inhibit_in, cycle_ad_drive_in, cycle_low_be_n_in;
  logic cycle_high_be_n_in, cycle_read_in, cycle_data_strobe_n_in, cycle_read_strobe_n_in;
  logic cycle_write_low_n_in, cycle_write_high_n_in, cycle_addr_strobe_n_in, clk_phase_in;
  logic want, granted, ph_prev, mux_addr_data_lines_oe_out, low_address_lines_oe_out;
  logic high_address_lines_oe_out, low_byte_enable_n_out, high_byte_enable_n_out;
  logic byte_enable_oe_out, read_write_status_out, read_write_status_oe_out, data_strobe_n_out;
  logic read_strobe_n_out, write_strobe_low_n_out, write_strobe_high_n_out, strobe_oe_out;
  logic address_strobe_n_out, address_strobe_oe_out, hold_acknowledge_n_out;
  logic hold_acknowledge_oe_out, hold_request_seen_out, system_clock_output_out;
  logic system_clock_output_oe_out;
  logic [`EBPC_AD_W-1:0] cycle_ad_in, mux_addr_data_lines_out;
  logic [`EBPC_LA_W-1:0] cycle_low_addr_in, low_address_lines_out;
  logic [`EBPC_HA_W-1:0] cycle_high_addr_in, high_address_lines_out;
  wire logic             hold_request_n_in;
  int                    error_cnt = 0, checks_done = 0, cyc = 0;
  ebpc_pin_ctrl u_dut (.*);
  ebpc_hold_mst u_mst (.mclk_in(mclk_in), .want_in(want), .ack_n_in(hold_acknowledge_n_out),
    .ack_oe_in(hold_acknowledge_oe_out), .hold_request_n_out(hold_request_n_in),
    .granted_out(granted));
  always #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      final_report();
    end
  end
  function automatic logic [8:0] oes();
    return {mux_addr_data_lines_oe_out, low_address_lines_oe_out, high_address_lines_oe_out,
      byte_enable_oe_out, read_write_status_oe_out, strobe_oe_out, address_strobe_oe_out,
      hold_acknowledge_oe_out, system_clock_output_oe_out};
  endfunction : oes
  task automatic step(input int n);
    repeat (n) begin
      ph_prev = clk_phase_in;
      @(posedge mclk_in);
      #1 clk_phase_in = ~clk_phase_in;
    end
  endtask : step
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic t_reset();
    expansion_mode_in = 1'b1;
    step(11);
    chk("oe in reset", oes(), 9'h000);
    step(1);
    rst_n_in = 1'b1;
    expansion_mode_in = 1'b0;
    step(1);
    chk("oe port mode", oes(), 9'h001);
  endtask : t_reset
  task automatic t_cycle();
    {expansion_mode_in, ext_cycle_in, cycle_ad_drive_in} = 3'b111;
    {cycle_ad_in, cycle_low_addr_in, cycle_high_addr_in} = {16'ha5c3, 15'h1234, 6'h2a};
    {cycle_low_be_n_in, cycle_high_be_n_in, cycle_read_in, cycle_data_strobe_n_in} = 4'b1000;
    {cycle_read_strobe_n_in, cycle_write_low_n_in} = 2'b10;
    {cycle_write_high_n_in, cycle_addr_strobe_n_in} = 2'b00;
    step(1);
    chk("oe active", oes(), 9'h1ff);
    chk("ad", mux_addr_data_lines_out, 16'ha5c3);
    chk("addr", {low_address_lines_out, high_address_lines_out}, {15'h1234, 6'h2a});
    chk("be rw ds", {low_byte_enable_n_out, high_byte_enable_n_out, read_write_status_out,
      data_strobe_n_out}, 4'b1000);
    chk("strobes", {read_strobe_n_out, write_strobe_low_n_out, write_strobe_high_n_out,
      address_strobe_n_out}, 4'b1000);
    cycle_ad_drive_in = 1'b0;
    step(1);
    chk("ad oe read", mux_addr_data_lines_oe_out, 1'b0);
  endtask : t_cycle
  task automatic t_quiet();
    for (int i = 0; i < 3; i++) begin
      {ext_cycle_in, internal_fetch_in, halt_in} = (i == 0) ? 3'b000 : {1'b1, i == 1, i == 2};
      {cycle_low_addr_in, cycle_high_addr_in, cycle_low_be_n_in} = {15'h7abc, 6'h15, 1'b0};
      step(1);
      chk("oe quiet", oes(), 9'h0ff);
      chk("held", {low_address_lines_out, high_address_lines_out, low_byte_enable_n_out},
        {15'h1234, 6'h2a, 1'b1});
      chk("high pins", {read_write_status_out, data_strobe_n_out, read_strobe_n_out,
        write_strobe_low_n_out, write_strobe_high_n_out, address_strobe_n_out,
        hold_acknowledge_n_out}, 7'h7f);
      chk("clk run", system_clock_output_out, ph_prev);
    end
    {ext_cycle_in, internal_fetch_in, halt_in} = 3'b000;
  endtask : t_quiet
  task automatic t_toggle();
    expansion_mode_in = 1'b0;
    step(1);
    expansion_mode_in = 1'b1;
    step(1);
    chk("held toggle", low_address_lines_out, 15'h1234);
  endtask : t_toggle
  task automatic t_hold();
    {want, halt_in} = 2'b11;
    step(2);
    chk("oe hold", oes(), 9'h083);
    chk("ack seen", {hold_acknowledge_n_out, granted, hold_request_seen_out},
      3'b011);
    stop_in = 1'b1;
    step(1);
    chk("oe stop", oes(), 9'h081);
    chk("stop clk seen", {system_clock_output_out, hold_request_seen_out}, 2'b00);
    {want, stop_in} = 2'b00;
    step(2);
  endtask : t_hold
  task automatic t_inhibit();
    system_clock_output_inhibit_in = 1'b1;
    step(1);
    chk("clk inhibit", {system_clock_output_oe_out, system_clock_output_out}, 2'b10);
    {system_clock_output_inhibit_in, halt_in} = 2'b00;
    step(1);
    chk("clk again", system_clock_output_out, ph_prev);
  endtask : t_inhibit
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    {expansion_mode_in, ext_cycle_in, internal_fetch_in, halt_in, stop_in, want} = '0;
    {system_clock_output_inhibit_in, cycle_ad_drive_in, cycle_read_in, clk_phase_in} = '0;
    {cycle_ad_in, cycle_low_addr_in, cycle_high_addr_in} = '0;
    {cycle_low_be_n_in, cycle_high_be_n_in, cycle_data_strobe_n_in} = '1;
    {cycle_read_strobe_n_in, cycle_write_low_n_in, cycle_write_high_n_in} = '1;
    cycle_addr_strobe_n_in = 1'b1;
    t_reset();
    t_cycle();
    t_quiet();
    t_toggle();
    t_hold();
    t_inhibit();
    final_report();
  end
endmodule : tb_ebpc_pin_ctrl
bind ebpc_pin_ctrl ebpc_pin_ctrl_chk u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .expansion_mode_in(expansion_mode_in),
  .ext_cycle_in(ext_cycle_in), .internal_fetch_in(internal_fetch_in), .halt_in(halt_in),
  .stop_in(stop_in), .hold_request_n_in(hold_request_n_in),
  .cycle_low_addr_in(cycle_low_addr_in), .low_address_lines_out(low_address_lines_out),
  .low_address_lines_oe_out(low_address_lines_oe_out),
  .mux_addr_data_lines_oe_out(mux_addr_data_lines_oe_out),
  .high_address_lines_oe_out(high_address_lines_oe_out),
  .byte_enable_oe_out(byte_enable_oe_out), .read_write_status_out(read_write_status_out),
  .read_write_status_oe_out(read_write_status_oe_out), .data_strobe_n_out(data_strobe_n_out),
  .strobe_oe_out(strobe_oe_out), .hold_acknowledge_n_out(hold_acknowledge_n_out),
  .hold_acknowledge_oe_out(hold_acknowledge_oe_out),
  .hold_request_seen_out(hold_request_seen_out),
  .system_clock_output_out(system_clock_output_out),
  .system_clock_output_oe_out(system_clock_output_oe_out)
);
